/* rtl/clkgen_consts.svh */
// timing counts, preset values and bit positions of the clock generator
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH

// preset values loaded at stop entry when the stabilisation select is 0
`define PRE12_STOP_LOAD   8'hFF
`define T1_STOP_LOAD      8'h01
// last main-edge count of a cpu clock half period in middle-speed mode (four edges)
`define MID_HALF_LAST     2'h3
// last main-edge count of a count-source tick (main / 16)
`define SRC_DIV_LAST      4'hF
// oscillator periods that reset must be held low
`define RESET_HOLD_OSC    16
// bit positions of the cpu mode controls; main stop is carried on a plain port, bit 3 has none
`define CPUM_MAIN_STOP    5
`define CPUM_FIXED_ONE    3

`endif

/* rtl/clkgen_pkg.sv */
// types shared by the clock generator modules
package clkgen_pkg;

  typedef enum logic [1:0] {
    MODE_MID  = 2'h0,
    MODE_HIGH = 2'h1,
    MODE_LOW  = 2'h2
  } clk_mode_t;

  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_WAIT = 4'h2,
    ST_STOP = 4'h4,
    ST_WAKE = 4'h8
  } gen_state_t;

  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] pre_latch;
    logic [7:0] t1;
    logic [7:0] t1_latch;
    logic       underflow;
  } timer_state_t;

endpackage

/* rtl/timer_if.sv */
// link between the clock generator and its prescaler/timer pair
`timescale 1ns/100ps
interface timer_if;
  logic       tick;
  logic       load_stop;
  logic       wr_pre;
  logic       wr_t1;
  logic [7:0] wr_data;
  logic [7:0] pre_count;
  logic [7:0] t1_count;
  logic       underflow;

  modport ctrl (output tick, load_stop, wr_pre, wr_t1, wr_data,
                input  pre_count, t1_count, underflow);
  modport tmr  (input  tick, load_stop, wr_pre, wr_t1, wr_data,
                output pre_count, t1_count, underflow);
endinterface

/* rtl/stab_timer.sv */
// prescaler 12 chained into timer 1, used as the wake-up delay counter
`timescale 1ns/100ps
`include "clkgen_consts.svh"
module stab_timer
  import clkgen_pkg::*;
(
  input  wire logic clk,    // system clock
  input  wire logic rst_n,  // asynchronous reset, active low
  timer_if.tmr      tif     // control and count link
);

  timer_state_t cur;
  timer_state_t next_s;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_s = cur;
    next_s.underflow = 1'b0;
    if (tif.load_stop) begin
      next_s.pre       = `PRE12_STOP_LOAD;
      next_s.pre_latch = `PRE12_STOP_LOAD;
      next_s.t1        = `T1_STOP_LOAD;
      next_s.t1_latch  = `T1_STOP_LOAD;
    end else begin
      if (tif.wr_pre) begin
        next_s.pre       = tif.wr_data;
        next_s.pre_latch = tif.wr_data;
      end
      if (tif.wr_t1) begin
        next_s.t1       = tif.wr_data;
        next_s.t1_latch = tif.wr_data;
      end
      // reload on zero gives a division by latch value plus one
      if (tif.tick && !tif.wr_pre) begin
        if (cur.pre == 8'h00) begin
          next_s.pre = cur.pre_latch;
          if (!tif.wr_t1) begin
            if (cur.t1 == 8'h00) begin
              next_s.t1        = cur.t1_latch;
              next_s.underflow = 1'b1;
            end else begin
              next_s.t1 = cur.t1 - 8'h01;
            end
          end
        end else begin
          next_s.pre = cur.pre - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{pre: 8'hFF, pre_latch: 8'hFF, t1: 8'h01,
               t1_latch: 8'h01, underflow: 1'b0};
    end else begin
      cur <= next_s;
    end
  end

  assign tif.pre_count = cur.pre;
  assign tif.t1_count  = cur.t1;
  assign tif.underflow = cur.underflow;

endmodule

/* rtl/sys_clock_gen.sv */
// system clock generator: speed modes, stop and wait with wake-up delay
// Operation
// - reset selects middle-speed: cpu clock is main oscillator / 8
// - high-speed: cpu clock is main oscillator / 2
// - low-speed: cpu clock is sub oscillator / 2
// - after power-on only main runs; sub pins act as port pins
// - main stop control halts main oscillator in low-speed mode
// - stop instruction holds cpu clock high, halts both oscillators
// - stabilisation select 0: stop loads prescaler FF, timer 1 01
// - stabilisation select 1: prescaler and timer left as software set
// - on stop release prescaler uses captured source, feeds timer 1
// - wake-up counting uses main oscillator / 16, or sub when captured source is 1
// - external interrupt restarts oscillator; clock waits for underflow
// - wait instruction holds cpu clock high, oscillators keep running
// - wait ends on reset or accepted interrupt, clock resumes at once
// - only interrupts enabled before the instruction release stop/wait
// - timer latch value n divides its input by n plus one
`timescale 1ns/100ps
`include "clkgen_consts.svh"
module sys_clock_gen
  import clkgen_pkg::*;
#(
  parameter int IRQ_W    = 8,                     // interrupt sources
  parameter logic [IRQ_W-1:0] EXT_MASK = 8'h0F    // external sources
)(
  input  wire logic             MCLK,             // 100 MHz clock
  input  wire logic             RST_N,            // async reset, low
  input  wire logic             MAIN_OSC_IN,      // main oscillator pin
  input  wire logic             SUB_OSC_IN,       // sub oscillator pin
  input  wire logic [1:0]       CLK_MODE,         // requested speed mode
  input  wire logic             MAIN_STOP,        // main clock stop ctl
  input  wire logic             SUB_EN,           // sub oscillator enable
  input  wire logic             STAB_SEL,         // stabilisation select
  input  wire logic             COUNT_SRC,        // 0 main/16, 1 sub
  input  wire logic             STOP_INSTRUCTION, // stop executed, pulse
  input  wire logic             WAIT_INSTRUCTION, // wait executed, pulse
  input  wire logic [IRQ_W-1:0] INT_REQ,          // interrupt requests
  input  wire logic [IRQ_W-1:0] INT_EN,           // interrupt enables
  input  wire logic             PRE12_WR,         // prescaler write
  input  wire logic             T1_WR,            // timer 1 write
  input  wire logic [7:0]       TIMER_WDATA,      // timer write data
  input  wire logic             PORT_DIR,         // sub pin port direction
  input  wire logic             PORT_DATA,        // sub pin port data
  output logic                  PHI,              // internal cpu clock
  output logic                  MAIN_OSC_EN,      // main amplifier on
  output logic                  SUB_OSC_EN,       // sub amplifier on
  output logic                  SUB_PORT_OE,      // sub pin port enable
  output logic                  SUB_PORT_DO,      // sub pin port data
  output logic [3:0]            CLK_STATE,        // one-hot run state
  output logic [1:0]            ACTIVE_MODE,      // mode in effect
  output logic [7:0]            PRE12_COUNT,      // prescaler 12 value
  output logic [7:0]            T1_COUNT,         // timer 1 value
  output logic                  T1_UNDERFLOW      // timer 1 underflow
);

  typedef struct packed {
    gen_state_t       st;
    clk_mode_t        mode;
    logic             phi;
    logic [1:0]       phi_cnt;
    logic [3:0]       src_cnt;
    logic [2:0]       main_s;
    logic [2:0]       sub_s;
    logic [IRQ_W-1:0] en_snap;
    logic             src_snap;
    logic             main_en;
    logic             sub_en;
    logic             port_oe;
    logic             port_do;
  } gen_reg_t;

  gen_reg_t cur;
  gen_reg_t next_s;
  timer_if  tif ();

  logic main_rise;
  logic sub_rise;
  logic run_edge;
  logic toggle;
  logic src_sel;

  function automatic logic rising(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction

  // -----------------------------------------------------------------
  // oscillator sampling and edge events
  // -----------------------------------------------------------------
  assign main_rise = rising(cur.main_s) & cur.main_en;
  assign sub_rise  = rising(cur.sub_s) & cur.sub_en;
  assign run_edge  = (cur.mode == MODE_LOW) ? sub_rise : main_rise;
  assign src_sel   = (cur.st == ST_WAKE) ? cur.src_snap : COUNT_SRC;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_s        = cur;
    toggle        = 1'b0;
    next_s.main_s = {cur.main_s[1:0], MAIN_OSC_IN};
    next_s.sub_s  = {cur.sub_s[1:0], SUB_OSC_IN};
    tif.tick      = 1'b0;
    tif.load_stop = 1'b0;
    tif.wr_pre    = PRE12_WR;
    tif.wr_t1     = T1_WR;
    tif.wr_data   = TIMER_WDATA;

    // count source for prescaler 12
    if (main_rise) begin
      next_s.src_cnt = cur.src_cnt + 4'h1;
    end
    if (src_sel) begin
      tif.tick = sub_rise;
    end else begin
      tif.tick = main_rise && (cur.src_cnt == `SRC_DIV_LAST);
    end

    case (cur.st)
      ST_RUN: begin
        if (run_edge) begin
          if (cur.mode == MODE_MID) begin
            toggle = (cur.phi_cnt == `MID_HALF_LAST);
            next_s.phi_cnt = cur.phi_cnt + 2'h1;
          end else begin
            toggle = 1'b1;
          end
        end
        if (toggle) begin
          next_s.phi = ~cur.phi;
          // a new mode takes effect only at a period boundary
          if (!cur.phi && (CLK_MODE != 2'h3)) begin
            next_s.mode    = clk_mode_t'(CLK_MODE);
            next_s.phi_cnt = 2'h0;
          end
        end
        next_s.sub_en  = SUB_EN;
        // main may only be stopped while the cpu runs from sub
        next_s.main_en = !(MAIN_STOP &&
                           next_s.mode == MODE_LOW);
        if (STOP_INSTRUCTION) begin
          next_s.st       = ST_STOP;
          next_s.phi      = 1'b1;
          next_s.phi_cnt  = 2'h0;
          next_s.main_en  = 1'b0;
          next_s.sub_en   = 1'b0;
          next_s.en_snap  = INT_EN;
          next_s.src_snap = COUNT_SRC;
          // with select 1 software owns the settling count
          tif.load_stop   = !STAB_SEL;
        end else if (WAIT_INSTRUCTION) begin
          next_s.st      = ST_WAIT;
          next_s.phi     = 1'b1;
          next_s.phi_cnt = 2'h0;
          next_s.en_snap = INT_EN;
        end
      end
      ST_WAIT: begin
        next_s.phi = 1'b1;
        if (|(INT_REQ & cur.en_snap)) begin
          next_s.st = ST_RUN;
        end
      end
      ST_STOP: begin
        next_s.phi = 1'b1;
        if (|(INT_REQ & cur.en_snap & EXT_MASK)) begin
          next_s.st      = ST_WAKE;
          next_s.main_en = 1'b1;
          next_s.sub_en  = SUB_EN;
          next_s.src_cnt = 4'h0;
        end
      end
      ST_WAKE: begin
        // clock stays high until the settling count runs out
        next_s.phi = 1'b1;
        if (tif.underflow) begin
          next_s.st = ST_RUN;
        end
      end
      default: begin
        next_s.st  = ST_RUN;
        next_s.phi = 1'b1;
      end
    endcase

    // sub pins are ordinary port pins while the sub oscillator is off
    next_s.port_oe = !next_s.sub_en && PORT_DIR;
    next_s.port_do = PORT_DATA;
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  // reset always lands in run: leaving stop by reset has no delay
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cur <= '{st: ST_RUN, mode: MODE_MID, phi: 1'b1,
               phi_cnt: 2'h0, src_cnt: 4'h0, main_s: 3'h0,
               sub_s: 3'h0, en_snap: '0, src_snap: 1'b0,
               main_en: 1'b1, sub_en: 1'b0, port_oe: 1'b0,
               port_do: 1'b0};
    end else begin
      cur <= next_s;
    end
  end

  // -----------------------------------------------------------------
  // prescaler 12 and timer 1
  // -----------------------------------------------------------------
  stab_timer u_timer (
    .clk   (MCLK),
    .rst_n (RST_N),
    .tif   (tif)
  );

  assign PHI          = cur.phi;
  assign MAIN_OSC_EN  = cur.main_en;
  assign SUB_OSC_EN   = cur.sub_en;
  assign SUB_PORT_OE  = cur.port_oe;
  assign SUB_PORT_DO  = cur.port_do;
  assign CLK_STATE    = cur.st;
  assign ACTIVE_MODE  = cur.mode;
  assign PRE12_COUNT  = tif.pre_count;
  assign T1_COUNT     = tif.t1_count;
  assign T1_UNDERFLOW = tif.underflow;

endmodule

/* verif/osc_model.sv */
// resonator model driving the main and sub oscillator pins
`timescale 1ns/100ps
module osc_model #(
  parameter int MAIN_HALF = 40,  // ns, main period is 8 MCLK cycles
  parameter int SUB_HALF  = 150  // ns, keeps main above 3x sub
)(
  input  wire logic main_en,   // main amplifier on
  input  wire logic sub_en,    // sub amplifier on
  output logic      main_wave, // main oscillator waveform
  output logic      sub_wave   // sub oscillator waveform
);
  // a halted resonator stops swinging, so the pin rests low
  initial begin
    main_wave = 1'b0;
    forever #(MAIN_HALF) main_wave = main_en ? !main_wave : 1'b0;
  end
  initial begin
    sub_wave = 1'b0;
    forever #(SUB_HALF) sub_wave = sub_en ? !sub_wave : 1'b0;
  end
endmodule

/* verif/clkgen_chk.sv */
// concurrent checks on the clock generator ports
`timescale 1ns/100ps
module clkgen_chk
  import clkgen_pkg::*;
#(
  parameter int               IRQ_W    = 8,
  parameter logic [IRQ_W-1:0] EXT_MASK = 8'h0F
)(
  input wire logic             MCLK,             // clock
  input wire logic             RST_N,            // reset
  input wire logic             MAIN_STOP,        // main stop
  input wire logic             STAB_SEL,         // preset select
  input wire logic             STOP_INSTRUCTION, // stop pulse
  input wire logic             WAIT_INSTRUCTION, // wait pulse
  input wire logic [IRQ_W-1:0] INT_REQ,          // requests
  input wire logic [IRQ_W-1:0] INT_EN,           // enables
  input wire logic             PHI,              // cpu clock
  input wire logic             MAIN_OSC_EN,      // main on
  input wire logic             SUB_OSC_EN,       // sub on
  input wire logic             SUB_PORT_OE,      // port drive
  input wire logic [3:0]       CLK_STATE,        // run state
  input wire logic [1:0]       ACTIVE_MODE,      // mode in effect
  input wire logic [7:0]       PRE12_COUNT,      // prescaler
  input wire logic [7:0]       T1_COUNT,         // timer 1
  input wire logic             T1_UNDERFLOW      // underflow
);
  logic [IRQ_W-1:0] cap;
  logic             taken;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // enables count only as they stood when the instruction was taken
  assign taken = CLK_STATE == 4'h1 && (STOP_INSTRUCTION || WAIT_INSTRUCTION);
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) cap <= '0;
    else if (taken) cap <= INT_EN;
  end
  a_phi_parked: assert property (CLK_STATE != 4'h1 |-> PHI)
    else $error("cpu clock not held high");
  a_stop_osc_off: assert property (CLK_STATE == 4'h4 |->
    !MAIN_OSC_EN && !SUB_OSC_EN) else $error("oscillator runs in stop");
  a_stop_preset: assert property (CLK_STATE == 4'h1 && STOP_INSTRUCTION &&
    !STAB_SEL |=> PRE12_COUNT == 8'hFF && T1_COUNT == 8'h01)
    else $error("stop preset wrong");
  a_wake_hold: assert property (CLK_STATE == 4'h8 && !T1_UNDERFLOW |=>
    CLK_STATE == 4'h8) else $error("wake left early");
  a_wake_run: assert property (CLK_STATE == 4'h8 && T1_UNDERFLOW |=>
    CLK_STATE == 4'h1) else $error("no run after underflow");
  a_wake_osc_on: assert property (CLK_STATE == 4'h8 |-> MAIN_OSC_EN)
    else $error("main off during wake");
  a_wait_wake: assert property (CLK_STATE == 4'h2 && |(INT_REQ & cap) |=>
    CLK_STATE == 4'h1) else $error("wait not released");
  a_wait_osc_run: assert property (CLK_STATE == 4'h2 && !MAIN_STOP |->
    MAIN_OSC_EN) else $error("main off in wait");
  a_stop_ext_only: assert property (CLK_STATE == 4'h4 &&
    !(|(INT_REQ & cap & EXT_MASK)) |=> CLK_STATE == 4'h4)
    else $error("stop left without enabled external request");
  a_sub_port_off: assert property (SUB_OSC_EN |-> !SUB_PORT_OE)
    else $error("port drives running sub pin");
  a_main_halt: assert property (CLK_STATE == 4'h1 && MAIN_STOP &&
    ACTIVE_MODE == 2'h2 |-> ##[1:2] !MAIN_OSC_EN)
    else $error("main not halted");
  c_wake: cover property (CLK_STATE == 4'h8 && T1_UNDERFLOW);
  c_wait: cover property (CLK_STATE == 4'h2 ##1 CLK_STATE == 4'h1);
  c_low: cover property (ACTIVE_MODE == 2'h2 && !MAIN_OSC_EN);
endmodule

bind sys_clock_gen clkgen_chk #(.IRQ_W(IRQ_W), .EXT_MASK(EXT_MASK))
  clkgen_chk_inst (.MCLK(MCLK), .RST_N(RST_N), .MAIN_STOP(MAIN_STOP),
  .STAB_SEL(STAB_SEL), .STOP_INSTRUCTION(STOP_INSTRUCTION),
  .WAIT_INSTRUCTION(WAIT_INSTRUCTION), .INT_REQ(INT_REQ), .INT_EN(INT_EN),
  .PHI(PHI), .MAIN_OSC_EN(MAIN_OSC_EN), .SUB_OSC_EN(SUB_OSC_EN),
  .SUB_PORT_OE(SUB_PORT_OE), .CLK_STATE(CLK_STATE),
  .ACTIVE_MODE(ACTIVE_MODE), .PRE12_COUNT(PRE12_COUNT),
  .T1_COUNT(T1_COUNT), .T1_UNDERFLOW(T1_UNDERFLOW));

/* verif/tb.sv */
// self-checking bench for the system clock generator
`timescale 1ns/100ps
module tb;
  import clkgen_pkg::*;
  typedef struct {
    logic [1:0] mode;
    int         per;
  } row_t;
  // requested mode beside the cpu clock period it gives, in MCLK cycles
  row_t       rows[5] = '{'{2'h0, 64}, '{2'h1, 16}, '{2'h3, 16},
                          '{2'h2, 60}, '{2'h0, 64}};
  logic       mclk, rst_n, mosc, sosc, mstop, suben, stab, stop_instruction, wait_instruction;
  logic       prew, t1w, pdir, pdat, phi, mosc_en, sosc_en, poe, pdo, uf;
  logic [1:0] mode, am;
  logic [3:0] st;
  logic [7:0] irq, ien, wd, pre, t1;
  int         failures, cmp_count, n;

  sys_clock_gen sys_clock_gen_inst (
    .MCLK(mclk), .RST_N(rst_n), .MAIN_OSC_IN(mosc), .SUB_OSC_IN(sosc),
    .CLK_MODE(mode), .MAIN_STOP(mstop), .SUB_EN(suben), .STAB_SEL(stab),
    .COUNT_SRC(1'b0), .STOP_INSTRUCTION(stop_instruction), .WAIT_INSTRUCTION(wait_instruction),
    .INT_REQ(irq), .INT_EN(ien), .PRE12_WR(prew), .T1_WR(t1w),
    .TIMER_WDATA(wd), .PORT_DIR(pdir), .PORT_DATA(pdat), .PHI(phi),
    .MAIN_OSC_EN(mosc_en), .SUB_OSC_EN(sosc_en), .SUB_PORT_OE(poe),
    .SUB_PORT_DO(pdo), .CLK_STATE(st), .ACTIVE_MODE(am),
    .PRE12_COUNT(pre), .T1_COUNT(t1), .T1_UNDERFLOW(uf));
  osc_model osc_model_inst (.main_en(mosc_en), .sub_en(sosc_en),
    .main_wave(mosc), .sub_wave(sosc));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic stall;
    failures++;
    $display("ERROR %0t wait timed out", $time);
    wrap_up();
  endtask
  // cycles from the call to the next rising edge of the cpu clock
  task automatic wait_phi(output int c);
    c = 0;
    while (phi !== 1'b0 && c < 400) begin @(negedge mclk); c++; end
    while (phi !== 1'b1 && c < 400) begin @(negedge mclk); c++; end
    if (c >= 400) stall();
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim, output int c);
    c = 0;
    while (st !== s && c < lim) begin @(negedge mclk); c++; end
    if (c >= lim) stall();
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask

  initial begin
    rst_n = 1'b0; mode = 2'h0; mstop = 1'b0; suben = 1'b0; stab = 1'b0;
    stop_instruction = 1'b0; wait_instruction = 1'b0; prew = 1'b0; t1w = 1'b0; pdir = 1'b1;
    pdat = 1'b1; irq = 8'h00; ien = 8'h00; wd = 8'h00;
    failures = 0; cmp_count = 0;
    repeat (12) @(negedge mclk);
    chk(phi === 1'b1 && st === 4'h1 && mosc_en === 1'b1 && sosc_en === 1'b0
      && pre === 8'hFF && t1 === 8'h01, "reset outputs");
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(am === 2'h0 && poe === 1'b1 && pdo === 1'b1, "after reset");
    suben = 1'b1;
    foreach (rows[i]) begin
      mode = rows[i].mode;
      wait_phi(n); wait_phi(n); wait_phi(n);
      chk(n == rows[i].per, "cpu clock period");
    end
    mode = 2'h2;
    wait_phi(n); wait_phi(n);
    mstop = 1'b1;
    repeat (4) @(negedge mclk);
    wait_phi(n); wait_phi(n);
    chk(mosc_en === 1'b0 && n == 60, "main stop in low mode");
    mstop = 1'b0; mode = 2'h0;
    wait_phi(n); wait_phi(n); wait_phi(n);
    chk(am === 2'h0, "back to middle speed");
    // an enable raised after the instruction must not release wait
    pulse(wait_instruction);
    chk(st === 4'h2 && phi === 1'b1 && mosc_en === 1'b1, "wait entry");
    ien = 8'h20; irq = 8'h20;
    repeat (8) @(negedge mclk);
    chk(st === 4'h2, "late enable released wait");
    irq = 8'h00; rst_n = 1'b0;
    @(negedge mclk) rst_n = 1'b1;
    @(negedge mclk);
    chk(st === 4'h1 && am === 2'h0, "reset ends wait");
    pulse(wait_instruction);
    irq = 8'h20;
    @(negedge mclk);
    chk(st === 4'h1, "interrupt ends wait at once");
    // timer 1 request stays disabled across stop, it counts the wake delay
    irq = 8'h00; ien = 8'h01;
    pulse(stop_instruction);
    chk(st === 4'h4 && pre === 8'hFF && t1 === 8'h01 && mosc_en === 1'b0
      && sosc_en === 1'b0, "stop entry preset");
    irq = 8'h20;
    repeat (8) @(negedge mclk);
    chk(st === 4'h4, "internal request left stop");
    // reset must cover oscillator start, since no wake delay is made
    irq = 8'h00; rst_n = 1'b0;
    repeat (128) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk(st === 4'h1, "reset ends stop");
    // cpu mode bit 3 has no port here; the core keeps it set
    stab = 1'b1; wd = 8'h03;
    pulse(prew);
    wd = 8'h02;
    pulse(t1w);
    pulse(stop_instruction);
    chk(st === 4'h4 && t1 === 8'h02, "stop kept written timer");
    irq = 8'h01;
    wait_st(4'h8, 4, n);
    irq = 8'h00;
    wait_st(4'h1, 3000, n);
    // (3+1)*(2+1) ticks of 16 main rises, 8 MCLK each, plus restart phase
    chk(n >= 1520 && n <= 1552, "wake delay length");
    chk(uf === 1'b0 && pre === 8'h03 && t1 === 8'h02, "reload");
    wrap_up();
  end
endmodule
